// ### bench/ato_monitor.sv
// Port checker for the timer output stage.
// Assumes single-cycle APB access; shadows a few written settings.
`timescale 1ns/1ps
module ato_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire logic second_break_input,
  input wire ato_pkg::ato_pins_s pins,
  input wire logic commutation_irq,
  input wire logic commutation_dma_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] brk_r;
  logic [15:0] ocfg_r;
  logic [11:0] ctrl_r;
  wire wr = psel && penable && pwrite;
  wire open_w = brk_r[7:6] == ato_pkg::LOCK_OFF;
  wire brk_w = wr && paddr == ato_pkg::A_BRK;
  wire [2:0] act_p = pins.pri[2:0] ^ ocfg_r[2:0];
  wire [2:0] act_c = pins.cmp ^ ocfg_r[6:4];
  wire [2:0] both = act_p & act_c & ~pins.pri_oe_n[2:0] & ~pins.cmp_oe_n;
  wire rel = pins.pri_oe_n == 4'hF && pins.cmp_oe_n == 3'h7;
  wire brk2 = brk_r[3] && second_break_input == brk_r[4];
  // Shadows follow software writes only; hardware break is not mirrored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_r <= 16'h0000;
      ocfg_r <= 16'h0000;
      ctrl_r <= 12'h000;
    end else begin
      if (wr && paddr == ato_pkg::A_CTRL)
        ctrl_r <= pwdata[11:0];
      if (brk_w && open_w)
        brk_r <= pwdata[15:0];
      else if (brk_w)
        brk_r[0] <= pwdata[0];
      if (wr && paddr == ato_pkg::A_OCFG && open_w)
        ocfg_r <= pwdata[15:0];
    end
  end
  sequence s_sw_brk;
    wr && paddr == ato_pkg::A_EVT && pwdata[ato_pkg::F_BG];
  endsequence
  sequence s_com;
    wr && paddr == ato_pkg::A_EVT && pwdata[ato_pkg::F_COMG];
  endsequence
  AST_PREADY: assert property (pready)
    else $error("pready low");
  AST_SLVERR: assert property (psel && penable |->
    pslverr == (paddr > ato_pkg::A_CNT || paddr[1:0] != 2'h0))
    else $error("pslverr does not match the address");
  AST_RST_PINS: assert property ($rose(presetn) |-> rel)
    else $error("pins driven right after reset");
  AST_OFF: assert property ((!brk_r[0] && !ocfg_r[15])[*3] |-> rel)
    else $error("pins driven without main enable");
  AST_SW_BRK: assert property (s_sw_brk ##1 !ocfg_r[15] |-> ##[1:3] rel)
    else $error("software break did not release pins");
  AST_IRQ: assert property (s_com ##0 ctrl_r[ato_pkg::F_COMIE]
    |=> commutation_irq)
    else $error("commutation irq missing");
  AST_IRQ_OFF: assert property (!ctrl_r[ato_pkg::F_COMIE] && $stable(ctrl_r)
    |-> !commutation_irq)
    else $error("commutation irq while disabled");
  AST_DMA: assert property (s_com ##0 ctrl_r[ato_pkg::F_COMDE]
    |=> commutation_dma_req ##1 !commutation_dma_req)
    else $error("commutation dma pulse wrong");
  AST_BRK2: assert property ((brk2 && ocfg_r[15])[*4]
    |-> ((pins.pri ^ ocfg_r[3:0]) & ~pins.pri_oe_n) == 4'h0)
    else $error("output active during second break");
  AST_DEAD: assert property (brk_r[0] |-> both == 3'h0)
    else $error("both outputs of a pair active");
endmodule
bind ato_output_stage ato_monitor ato_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .second_break_input(second_break_input),
  .pins(pins), .commutation_irq(commutation_irq),
  .commutation_dma_req(commutation_dma_req)
);

// ### bench/ato_power_stage.sv
// Power stage model: fault lines and the channel-2 sensor edge.
// Assumes the bench commands faults; first fault may report late.
`timescale 1ns/1ps
module ato_power_stage (
  // Clock
  input wire logic pclk,
  // Commands from the bench
  input wire logic fault1_req,
  input wire logic fault2_req,
  input wire logic edge_req,
  input wire logic [3:0] lag,
  // Fault and sensor lines
  output logic first_break_input,
  output logic second_break_input,
  output logic filtered_channel2_input
);
  logic [15:0] hist_r = 16'h0000;
  // Slow detector: fault shows lag cycles after the request
  always @(posedge pclk)
    hist_r <= {hist_r[14:0], fault1_req};
  assign first_break_input = lag == 4'h0 ? fault1_req : hist_r[lag - 4'h1];
  assign second_break_input = fault2_req;
  assign filtered_channel2_input = edge_req;
endmodule

// ### bench/tb.sv
// Self-checking bench for the timer output stage.
// Assumes one-cycle APB answers and a 100-count up period.
`timescale 1ns/1ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h3D;
  logic pready, pslverr, irq, dma, b1, b2, ch2, mv;
  logic ext_trig = 0, f1 = 0, f2 = 0, edg = 0;
  logic [3:0] lag = 4'h0;
  ato_pkg::ato_pins_s pins;
  int bad_count = 0, checks = 0, hi[7], c[4];
  logic [3:0] om2[3] = '{4'h6, 4'hC, 4'hE};
  logic [3:0] om4[3] = '{4'h7, 4'hD, 4'hF};
  logic [15:0] dtv[3] = '{16'h0301, 16'h0221, 16'h0321};
  int pexp[3] = '{37, 8, 0};
  int cexp[3] = '{57, 28, 12};
  always #12.5 pclk = ~pclk;
  ato_output_stage ato_output_stage_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_break_input(b1), .second_break_input(b2),
    .filtered_channel2_input(ch2), .ext_trigger_input(ext_trig),
    .pins(pins), .commutation_irq(irq), .commutation_dma_req(dma));
  ato_power_stage ato_power_stage_inst (.pclk(pclk), .fault1_req(f1),
    .fault2_req(f2), .edge_req(edg), .lag(lag), .first_break_input(b1),
    .second_break_input(b2), .filtered_channel2_input(ch2));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int and_duty(int lo, int up);
    return (up > lo) ? up - lo : 0;
  endfunction
  function automatic int or_duty(int a, int b);
    return a + 100 - b - ((a > b) ? a - b : 0);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic moving(output logic m);
    logic [31:0] a;
    apb(1'b0, ato_pkg::A_CNT, 32'h0);
    a = rd;
    apb(1'b0, ato_pkg::A_CNT, 32'h0);
    m = rd != a;
  endtask
  // High cycles of every pin over one full period
  task automatic duty();
    hi = '{default: 0};
    repeat (110) @(posedge pclk);
    repeat (100) begin
      @(negedge pclk);
      for (int i = 0; i < 4; i++)
        hi[i] += pins.pri[i];
      for (int i = 0; i < 3; i++)
        hi[4 + i] += pins.cmp[i];
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ato_pkg::A_RELOAD, 32'h0000FFFF);
    rdc(ato_pkg::A_BRK, 32'h0);
    check(pins.pri_oe_n, 4'hF);
    rdc(8'h34, 32'h0);
    $display("test reset done");
    wr(ato_pkg::A_RELOAD, 32'h63);
    wr(ato_pkg::A_ENA, 32'hF);
    wr(ato_pkg::A_BRK, 32'h1);
    wr(ato_pkg::A_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 4; j++)
        c[j] = int'(xs() % 32'h64);
      // Corner: compare beyond the period keeps references high
      if (k == 0)
        c = '{0, 100, 100, 0};
      for (int j = 0; j < 4; j++)
        wr(ato_pkg::A_CMP0 + 8'(4 * j), 32'(c[j]));
      wr(ato_pkg::A_MODE, {16'h0, om4[k], 4'hC, om2[k], 4'hD});
      duty();
      check(hi[0], and_duty(c[0], c[1]));
      check(hi[1], c[1]);
      check(hi[2], or_duty(c[2], c[3]));
      check(hi[3], 100 - c[3]);
    end
    $display("test combined done");
    wr(ato_pkg::A_MODE, 32'h0666);
    for (int j = 0; j < 3; j++)
      wr(ato_pkg::A_CMP0 + 8'(4 * j), 32'h28);
    wr(ato_pkg::A_ENA, 32'h7F);
    for (int k = 0; k < 3; k++) begin
      wr(ato_pkg::A_BRK, {16'h0, dtv[k]});
      duty();
      for (int i = 0; i < 3; i++) begin
        check(hi[i], pexp[k]);
        check(hi[4 + i], cexp[k]);
      end
    end
    $display("test dead time done");
    wr(ato_pkg::A_CTRL, 32'hC01);
    wr(ato_pkg::A_MODE, 32'h0667);
    rdc(ato_pkg::A_MODE, 32'h06660667);
    wr(ato_pkg::A_EVT, 32'h2);
    rdc(ato_pkg::A_MODE, 32'h06670667);
    rdc(ato_pkg::A_STAT, 32'h1);
    check(irq, 1'b1);
    wr(ato_pkg::A_STAT, 32'h1);
    @(negedge pclk);
    check(irq, 1'b0);
    wr(ato_pkg::A_MODE, 32'h0666);
    ext_trig <= 1'b1;
    repeat (3) @(posedge pclk);
    ext_trig <= 1'b0;
    rdc(ato_pkg::A_MODE, 32'h06660666);
    $display("test commutation done");
    wr(ato_pkg::A_STAT, 32'h7);
    wr(ato_pkg::A_BRK, 32'h0307);
    lag <= 4'(xs());
    f1 <= 1'b1;
    repeat (24) @(posedge pclk);
    check(pins.pri_oe_n, 4'hF);
    rdc(ato_pkg::A_BRK, 32'h0306);
    rdc(ato_pkg::A_STAT, 32'h2);
    f1 <= 1'b0;
    repeat (20) @(posedge pclk);
    wr(ato_pkg::A_BRK, 32'h0303);
    rdc(ato_pkg::A_BRK, 32'h0302);
    wr(ato_pkg::A_BRK, 32'h0300);
    wr(ato_pkg::A_STAT, 32'h7);
    wr(ato_pkg::A_BRK, 32'h0301);
    rdc(ato_pkg::A_BRK, 32'h0301);
    wr(ato_pkg::A_EVT, 32'h4);
    rdc(ato_pkg::A_BRK, 32'h0300);
    rdc(ato_pkg::A_STAT, 32'h2);
    wr(ato_pkg::A_OCFG, 32'h8001);
    f2 <= 1'b1;
    wr(ato_pkg::A_BRK, 32'h0319);
    repeat (4) @(posedge pclk);
    check(pins.pri[0], 1'b1);
    rdc(ato_pkg::A_STAT, 32'h6);
    f2 <= 1'b0;
    wr(ato_pkg::A_STAT, 32'h7);
    $display("test break done");
    wr(ato_pkg::A_CTRL, 32'h0362);
    moving(mv);
    check(mv, 1'b0);
    edg <= 1'b1;
    repeat (3) @(posedge pclk);
    edg <= 1'b0;
    moving(mv);
    check(mv, 1'b1);
    repeat (110) @(posedge pclk);
    moving(mv);
    check(mv, 1'b0);
    $display("test one pulse done");
    wr(ato_pkg::A_BRK, 32'h03C1);
    wr(ato_pkg::A_BRK, 32'h0500);
    rdc(ato_pkg::A_BRK, 32'h03C0);
    wr(ato_pkg::A_OCFG, 32'h0);
    rdc(ato_pkg::A_OCFG, 32'h8001);
    wr(ato_pkg::A_MODE, 32'h4444);
    rdc(ato_pkg::A_MODE, 32'h06660666);
    $display("test lock done");
    complete_run();
  end
endmodule

// ### inc/ato_pkg.sv
// Constants, register map and pin carrier for the timer output stage.
// Assumes a 32-bit APB bus with 8-bit byte addresses.
package ato_pkg;
  localparam int CNT_W = 16;
  localparam int DTG_W = 8;
  localparam int DT_W = 12;
  localparam int DT_PSC_SH = 4;
  localparam int NCH = 4;
  localparam int NCP = 3;

  // Byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RELOAD = 8'h04;
  localparam logic [7:0] A_CMP0 = 8'h08;
  localparam logic [7:0] A_CMP_SPAN = 8'h10;
  localparam logic [7:0] A_MODE = 8'h18;
  localparam logic [7:0] A_ENA = 8'h1C;
  localparam logic [7:0] A_OCFG = 8'h20;
  localparam logic [7:0] A_BRK = 8'h24;
  localparam logic [7:0] A_EVT = 8'h28;
  localparam logic [7:0] A_STAT = 8'h2C;
  localparam logic [7:0] A_CNT = 8'h30;

  // Control fields
  localparam int F_CEN = 0;
  localparam int F_OPM = 1;
  localparam int F_CMS = 2;
  localparam int F_SMS = 4;
  localparam int F_TS = 7;
  localparam int F_COMIE = 10;
  localparam int F_COMDE = 11;
  // Enable fields, active copy sits 16 bits higher on read
  localparam int F_CE = 0;
  localparam int F_CNE = 4;
  localparam int F_ACT = 16;
  // Output configuration fields
  localparam int F_POL = 0;
  localparam int F_NPOL = 4;
  localparam int F_OIS = 8;
  localparam int F_OISN = 12;
  localparam int F_OSSI = 15;
  // Break and dead-time fields
  localparam int F_MOE = 0;
  localparam int F_BKE = 1;
  localparam int F_BKP = 2;
  localparam int F_BKE2 = 3;
  localparam int F_BKP2 = 4;
  localparam int F_DTPSC = 5;
  localparam int F_LOCK = 6;
  localparam int F_DTG = 8;
  // Event and status fields
  localparam int F_UG = 0;
  localparam int F_COMG = 1;
  localparam int F_BG = 2;
  localparam int F_B2G = 3;
  localparam int F_COMIF = 0;
  localparam int F_BIF = 1;
  localparam int F_B2IF = 2;

  // Write masks under lock
  localparam logic [15:0] M_ALL = 16'hFFFF;
  localparam logic [15:0] M_BRK_LK = 16'h0001;
  localparam logic [15:0] M_OCFG_LK1 = 16'h007F;
  localparam logic [1:0] LOCK_OFF = 2'h0;
  localparam logic [1:0] LOCK_L1 = 2'h1;
  localparam logic [1:0] LOCK_L3 = 2'h3;

  // Reset values
  localparam logic [11:0] RST_CTRL = 12'h000;
  localparam logic [15:0] RST_RELOAD = 16'hFFFF;
  localparam logic [15:0] RST_REG = 16'h0000;

  // Counter modes and slave settings
  localparam logic [1:0] CMS_UP = 2'h0;
  localparam logic [1:0] CMS_DOWN = 2'h1;
  localparam logic [2:0] SMS_TRIG = 3'h6;
  localparam logic [2:0] TS_CH2 = 3'h6;

  // Output mode codes
  localparam logic [3:0] OM_SETM = 4'h1;
  localparam logic [3:0] OM_CLRM = 4'h2;
  localparam logic [3:0] OM_TGL = 4'h3;
  localparam logic [3:0] OM_FLO = 4'h4;
  localparam logic [3:0] OM_FHI = 4'h5;
  localparam logic [3:0] OM_PWM1 = 4'h6;
  localparam logic [3:0] OM_PWM2 = 4'h7;
  localparam logic [3:0] OM_CMB_OR = 4'hC;
  localparam logic [3:0] OM_CMB_AND = 4'hD;
  localparam logic [3:0] OM_ASY1 = 4'hE;
  localparam logic [3:0] OM_ASY2 = 4'hF;

  typedef enum logic {ATO_UP, ATO_DOWN} ato_dir_e;

  typedef struct packed {
    logic [3:0] pri;
    logic [3:0] pri_oe_n;
    logic [2:0] cmp;
    logic [2:0] cmp_oe_n;
  } ato_pins_s;
endpackage

// ### rtl/ato_output_stage.sv
// Advanced timer output stage: counter, compare references, combined
// PWM, dead time, break, lock, commutation and one-pulse start.
// Assumes an APB master on pclk and inputs synchronous to pclk.
//
// Overview of operation
// - Combined output is AND/OR of two references
// - Pairs 1/2 and 3/4 select codes 1100/1101
// - 1101/0111 low below compare; 0110/1100 high
// - 1101 pair gives AND, 1100 pair gives OR
// - Channels 1-3 give complementary output pairs
// - Each output has its own polarity bit
// - Complement drives with main, channel, complement enables
// - Outputs rise one dead time after reference edge
// - Dead time is field times 1 or 16 clocks
// - Break disables outputs into a safe state
// - Break1 idle level after dead time; break2 inactive
// - Off-state select drives inactive or releases pins
// - Breaks and main enable off after reset
// - Break polarity selectable; software break always works
// - Three lock levels freeze protected settings
// - Mode and enables preloaded, moved on commutation
// - Commutation from software bit or trigger rise
// - Commutation sets flag, interrupt and DMA request
// - One-pulse stops counter at first update
// - Trigger mode starts counter without software
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module ato_output_stage #(
  parameter int CW = ato_pkg::CNT_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power stage faults and triggers
  input wire logic first_break_input,
  input wire logic second_break_input,
  input wire logic filtered_channel2_input,
  input wire logic ext_trigger_input,
  // Output pins and events
  output ato_pkg::ato_pins_s pins,
  output logic commutation_irq,
  output logic commutation_dma_req
);

  localparam int NCH = ato_pkg::NCH;
  localparam int NCP = ato_pkg::NCP;
  localparam int DTW = ato_pkg::DT_W;

  logic [11:0] ctrl_r;
  logic [11:0] ctrl_w;
  logic [11:0] ctrl_nxt;
  logic [CW-1:0] reload_r;
  logic [CW-1:0] cmp_r [NCH];
  logic [15:0] mode_p_r;
  logic [15:0] mode_a_r;
  logic [6:0] ena_p_r;
  logic [6:0] ena_a_r;
  logic [15:0] ocfg_r;
  logic [15:0] brk_r;
  logic [15:0] brk_w;
  logic [15:0] brk_nxt;
  logic [2:0] stat_r;
  logic [2:0] stat_set;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  ato_pkg::ato_dir_e dir_r;
  ato_pkg::ato_dir_e dir_nxt;
  logic [NCH-1:0] ref_r;
  logic [NCH-1:0] ref_nxt;
  logic [NCH-1:0] oref;
  logic trg_d_r;
  logic [DTW-1:0] bkd_r;
  logic [31:0] prdata_r;
  logic dma_r;
  ato_pkg::ato_pins_s pins_r;
  ato_pkg::ato_pins_s pins_nxt;

  // Channel reference from mode, count and compare
  function automatic logic ref_f(input logic [3:0] m,
                                 input logic [CW-1:0] c,
                                 input logic [CW-1:0] v,
                                 input logic prev);
    logic below;
    logic hit;
    below = c < v;
    hit = c == v;
    case (m)
      ato_pkg::OM_SETM: ref_f = hit | prev;
      ato_pkg::OM_CLRM: ref_f = ~hit & prev;
      ato_pkg::OM_TGL: ref_f = hit ^ prev;
      ato_pkg::OM_FLO: ref_f = 1'b0;
      ato_pkg::OM_FHI: ref_f = 1'b1;
      ato_pkg::OM_PWM1, ato_pkg::OM_CMB_OR, ato_pkg::OM_ASY1:
        ref_f = below;
      ato_pkg::OM_PWM2, ato_pkg::OM_CMB_AND, ato_pkg::OM_ASY2:
        ref_f = ~below;
      default: ref_f = prev;
    endcase
  endfunction

  // Pair combination picked by the odd channel's mode
  function automatic logic comb_f(input logic [3:0] m,
                                  input logic a,
                                  input logic b);
    case (m)
      ato_pkg::OM_CMB_OR: comb_f = a | b;
      ato_pkg::OM_CMB_AND: comb_f = a & b;
      default: comb_f = a;
    endcase
  endfunction

  // Bus decode; zero-wait slave
  logic wr;
  logic rd_setup;
  logic hit;
  logic is_cmp;
  logic [1:0] cidx;
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit = (paddr <= ato_pkg::A_CNT) & (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign is_cmp = (paddr >= ato_pkg::A_CMP0) &
    (paddr < ato_pkg::A_CMP0 + ato_pkg::A_CMP_SPAN);
  assign cidx = 2'(paddr[4:2] - 3'(ato_pkg::A_CMP0 >> 2));

  logic wr_ctrl;
  logic wr_rld;
  logic wr_mode;
  logic wr_ena;
  logic wr_ocfg;
  logic wr_brk;
  logic wr_evt;
  logic wr_stat;
  assign wr_ctrl = wr & (paddr == ato_pkg::A_CTRL);
  assign wr_rld = wr & (paddr == ato_pkg::A_RELOAD);
  assign wr_mode = wr & (paddr == ato_pkg::A_MODE);
  assign wr_ena = wr & (paddr == ato_pkg::A_ENA);
  assign wr_ocfg = wr & (paddr == ato_pkg::A_OCFG);
  assign wr_brk = wr & (paddr == ato_pkg::A_BRK);
  assign wr_evt = wr & (paddr == ato_pkg::A_EVT);
  assign wr_stat = wr & (paddr == ato_pkg::A_STAT);

  // Lock masks; level is writable only while off, then fixed until reset
  logic [1:0] lock;
  logic [15:0] brk_m;
  logic [15:0] ocfg_m;
  logic pre_wok;
  assign lock = brk_r[ato_pkg::F_LOCK +: 2];
  assign brk_m = (lock == ato_pkg::LOCK_OFF) ? ato_pkg::M_ALL :
    ato_pkg::M_BRK_LK;
  assign ocfg_m = (lock == ato_pkg::LOCK_OFF) ? ato_pkg::M_ALL :
    (lock == ato_pkg::LOCK_L1) ? ato_pkg::M_OCFG_LK1 : 16'h0000;
  assign pre_wok = lock != ato_pkg::LOCK_L3;

  // Field views
  logic cen;
  logic opm;
  logic [1:0] cms;
  logic [2:0] sms;
  logic [2:0] ts;
  logic moe;
  logic ossi;
  logic [DTW-1:0] dt_cyc;
  logic [DTW-1:0] dt_load;
  logic [NCH-1:0] pol;
  logic [NCH-1:0] ois;
  logic [NCP-1:0] npol;
  logic [NCP-1:0] oisn;
  logic [NCH-1:0] ce_a;
  logic [NCP-1:0] cne_a;
  assign cen = ctrl_r[ato_pkg::F_CEN];
  assign opm = ctrl_r[ato_pkg::F_OPM];
  assign cms = ctrl_r[ato_pkg::F_CMS +: 2];
  assign sms = ctrl_r[ato_pkg::F_SMS +: 3];
  assign ts = ctrl_r[ato_pkg::F_TS +: 3];
  assign moe = brk_r[ato_pkg::F_MOE];
  assign ossi = ocfg_r[ato_pkg::F_OSSI];
  assign pol = ocfg_r[ato_pkg::F_POL +: NCH];
  assign ois = ocfg_r[ato_pkg::F_OIS +: NCH];
  assign npol = ocfg_r[ato_pkg::F_NPOL +: NCP];
  assign oisn = ocfg_r[ato_pkg::F_OISN +: NCP];
  assign ce_a = ena_a_r[ato_pkg::F_CE +: NCH];
  assign cne_a = ena_a_r[ato_pkg::F_CNE +: NCP];
  assign dt_cyc = brk_r[ato_pkg::F_DTPSC] ?
    (DTW'(brk_r[ato_pkg::F_DTG +: ato_pkg::DTG_W]) << ato_pkg::DT_PSC_SH) :
    DTW'(brk_r[ato_pkg::F_DTG +: ato_pkg::DTG_W]);
  // Edge cycle already counts once; zero field still costs that cycle
  assign dt_load = (dt_cyc == '0) ? '0 : dt_cyc - 1'b1;

  // Events
  logic trg_sel;
  logic trg_rise;
  logic start;
  logic ug;
  logic com;
  logic bk1;
  logic bk2;
  assign trg_sel = (ts == ato_pkg::TS_CH2) ? filtered_channel2_input :
    ext_trigger_input;
  assign trg_rise = trg_sel & ~trg_d_r;
  assign start = (sms == ato_pkg::SMS_TRIG) & trg_rise;
  assign ug = wr_evt & pwdata[ato_pkg::F_UG];
  assign com = (wr_evt & pwdata[ato_pkg::F_COMG]) | trg_rise;
  assign bk1 = (brk_r[ato_pkg::F_BKE] &
    (first_break_input == brk_r[ato_pkg::F_BKP])) |
    (wr_evt & pwdata[ato_pkg::F_BG]);
  assign bk2 = (brk_r[ato_pkg::F_BKE2] &
    (second_break_input == brk_r[ato_pkg::F_BKP2])) |
    (wr_evt & pwdata[ato_pkg::F_B2G]);

  // Counter
  logic at_top;
  logic at_bot;
  logic run_upd;
  assign at_top = cnt_r == reload_r;
  assign at_bot = cnt_r == '0;
  assign run_upd = cen & ((cms == ato_pkg::CMS_UP & at_top) |
    (cms == ato_pkg::CMS_DOWN & at_bot) |
    (cms[1] & dir_r == ato_pkg::ATO_DOWN & at_bot));

  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (ug) begin
      cnt_nxt = (cms == ato_pkg::CMS_DOWN) ? reload_r : '0;
      dir_nxt = (cms == ato_pkg::CMS_DOWN) ? ato_pkg::ATO_DOWN :
        ato_pkg::ATO_UP;
    end else if (cen) begin
      if (cms[1]) begin
        if (dir_r == ato_pkg::ATO_UP) begin
          cnt_nxt = at_top ? cnt_r - 1'b1 : cnt_r + 1'b1;
          dir_nxt = at_top ? ato_pkg::ATO_DOWN : ato_pkg::ATO_UP;
        end else begin
          cnt_nxt = at_bot ? cnt_r + 1'b1 : cnt_r - 1'b1;
          dir_nxt = at_bot ? ato_pkg::ATO_UP : ato_pkg::ATO_DOWN;
        end
      end else if (cms == ato_pkg::CMS_DOWN) begin
        cnt_nxt = at_bot ? reload_r : cnt_r - 1'b1;
      end else begin
        cnt_nxt = at_top ? '0 : cnt_r + 1'b1;
      end
    end
  end

  // Trigger start beats a one-pulse stop in the same cycle
  assign ctrl_w = wr_ctrl ? pwdata[11:0] : ctrl_r;
  always_comb begin
    ctrl_nxt = ctrl_w;
    ctrl_nxt[ato_pkg::F_CEN] = start |
      (ctrl_w[ato_pkg::F_CEN] & ~(opm & run_upd));
  end

  // Breaks win over a software write of the main enable
  assign brk_w = wr_brk ? ((pwdata[15:0] & brk_m) | (brk_r & ~brk_m)) :
    brk_r;
  always_comb begin
    brk_nxt = brk_w;
    if (bk1 | bk2) begin
      brk_nxt[ato_pkg::F_MOE] = 1'b0;
    end
  end

  always_comb begin
    stat_set = 3'h0;
    stat_set[ato_pkg::F_COMIF] = com;
    stat_set[ato_pkg::F_BIF] = bk1;
    stat_set[ato_pkg::F_B2IF] = bk2;
  end

  // References and pair combination
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ref
      assign ref_nxt[gi] = ref_f(mode_a_r[4*gi +: 4], cnt_r, cmp_r[gi],
        ref_r[gi]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_r[gi] <= '0;
        end else if (wr & (paddr == ato_pkg::A_CMP0 + 8'(4 * gi))) begin
          cmp_r[gi] <= pwdata[CW-1:0];
        end
      end
    end
  endgenerate
  assign oref[0] = comb_f(mode_a_r[3:0], ref_r[0], ref_r[1]);
  assign oref[1] = ref_r[1];
  assign oref[2] = comb_f(mode_a_r[11:8], ref_r[2], ref_r[3]);
  assign oref[3] = ref_r[3];

  // Dead time per complementary channel
  logic [NCH-1:0] pact;
  logic [NCP-1:0] nact;
  logic [NCP-1:0] refd_r;
  logic [DTW-1:0] dtc_r [NCP];
  generate
    for (gi = 0; gi < NCP; gi++) begin : g_dt
      logic done;
      // Edge reloads the count, so short pulses never appear
      assign done = (dtc_r[gi] == '0) & (oref[gi] == refd_r[gi]);
      assign pact[gi] = cne_a[gi] ? (refd_r[gi] & done) : oref[gi];
      assign nact[gi] = ~refd_r[gi] & done;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          refd_r[gi] <= 1'b0;
          dtc_r[gi] <= '0;
        end else begin
          refd_r[gi] <= oref[gi];
          dtc_r[gi] <= (oref[gi] != refd_r[gi]) ? dt_load :
            (dtc_r[gi] != '0) ? dtc_r[gi] - 1'b1 : dtc_r[gi];
        end
      end
    end
  endgenerate
  assign pact[3] = oref[3];

  // Output pins
  logic off_inact;
  assign off_inact = stat_r[ato_pkg::F_B2IF] | bk2 | (bkd_r != '0);
  assign pins_nxt.pri = moe ? (pact ^ pol) :
    (off_inact ? pol : ois);
  assign pins_nxt.pri_oe_n = moe ? ~ce_a : {NCH{~ossi}};
  assign pins_nxt.cmp = moe ? (nact ^ npol) :
    (off_inact ? npol : oisn);
  assign pins_nxt.cmp_oe_n = moe ? ~(ce_a[NCP-1:0] & cne_a) :
    {NCP{~ossi}};

  // Preload moves at once while no complement is in use
  logic xfer;
  assign xfer = com | ~(|cne_a);

  // Read data
  logic [31:0] rd_val;
  assign rd_val =
    (paddr == ato_pkg::A_CTRL) ? 32'(ctrl_r) :
    (paddr == ato_pkg::A_RELOAD) ? 32'(reload_r) :
    is_cmp ? 32'(cmp_r[cidx]) :
    (paddr == ato_pkg::A_MODE) ? {mode_a_r, mode_p_r} :
    (paddr == ato_pkg::A_ENA) ?
      32'({ena_a_r, 9'h000, ena_p_r}) :
    (paddr == ato_pkg::A_OCFG) ? 32'(ocfg_r) :
    (paddr == ato_pkg::A_BRK) ? 32'(brk_r) :
    (paddr == ato_pkg::A_STAT) ? 32'(stat_r) :
    (paddr == ato_pkg::A_CNT) ? 32'(cnt_r) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ato_pkg::RST_CTRL;
      reload_r <= CW'(ato_pkg::RST_RELOAD);
      brk_r <= ato_pkg::RST_REG;
      ocfg_r <= ato_pkg::RST_REG;
      stat_r <= 3'h0;
      cnt_r <= '0;
      dir_r <= ato_pkg::ATO_UP;
      ref_r <= '0;
      trg_d_r <= 1'b0;
      bkd_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      reload_r <= wr_rld ? pwdata[CW-1:0] : reload_r;
      brk_r <= brk_nxt;
      ocfg_r <= wr_ocfg ? ((pwdata[15:0] & ocfg_m) | (ocfg_r & ~ocfg_m)) :
        ocfg_r;
      // Hardware set wins over write-one-to-clear
      stat_r <= (stat_r & ~(wr_stat ? pwdata[2:0] : 3'h0)) | stat_set;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      ref_r <= ref_nxt;
      trg_d_r <= trg_sel;
      bkd_r <= bk1 ? dt_cyc : (bkd_r != '0) ? bkd_r - 1'b1 : bkd_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_p_r <= ato_pkg::RST_REG;
      mode_a_r <= ato_pkg::RST_REG;
      ena_p_r <= 7'h00;
      ena_a_r <= 7'h00;
    end else begin
      if (wr_mode & pre_wok) begin
        mode_p_r <= pwdata[15:0];
      end
      if (wr_ena & pre_wok) begin
        ena_p_r <= pwdata[6:0];
      end
      if (xfer) begin
        mode_a_r <= mode_p_r;
        ena_a_r <= ena_p_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pins_r <= '{pri: 4'h0, pri_oe_n: 4'hF, cmp: 3'h0, cmp_oe_n: 3'h7};
      dma_r <= 1'b0;
    end else begin
      prdata_r <= rd_setup ? rd_val : prdata_r;
      pins_r <= pins_nxt;
      dma_r <= com & ctrl_r[ato_pkg::F_COMDE];
    end
  end

  assign prdata = prdata_r;
  assign pins = pins_r;
  assign commutation_irq = stat_r[ato_pkg::F_COMIF] &
    ctrl_r[ato_pkg::F_COMIE];
  assign commutation_dma_req = dma_r;

endmodule
